// ===== inc/pfl_pkg.sv
// What this block does
// (RULE1) Flow pin low when able to accept
// (RULE2) Flow pin high below stop free space
// (RULE3) Flow pin low above resume free space
// (RULE4) Between thresholds, flow pin holds its level
// (RULE5) Reset thresholds: stop 20, resume 40
// (RULE6) Control packet field replaces both thresholds
// (RULE7) Sender raises thresholds if too slow stopping; pfl_host never raises them, they change only on thr_load
// (RULE8) Flow pin generated for every packet interface
// (RULE9) Frame strobe high at least 250 us
// (RULE10) Frame strobe period 20 ms, 1 ms tolerance
// (RULE11) Strobe edge interval sets samples per frame
// (RULE12) Transmit-pending rises once packet ready
// (RULE13) Transmit-pending falls after whole packet read
// (RULE14) Standby permit low 500 ns before sending
// (RULE15) Standby permit ignored without low power mode
// (RULE16) Enable-generation output looped to slave enable
// (RULE17) Codec frame sync driven by codec sync
// (RULE18) Standby only in low power, else idle
package pfl_pkg;

  // ==========================================================
  // Buffers
  localparam int unsigned BUF_DEPTH = 64;
  localparam int unsigned PTR_W     = 6;
  localparam int unsigned CNT_W     = 7;

  // ==========================================================
  // Flow thresholds in bytes of free space
  localparam logic [6:0] STOP_RST   = 7'h14;
  localparam logic [6:0] RESUME_RST = 7'h28;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_NS       = 25;
  localparam int unsigned SAMPLE_NS    = 125000;
  localparam int unsigned STROBE_HI_US = 250;
  localparam int unsigned FRAME_US     = 20000;
  localparam int unsigned PERMIT_NS    = 500;
  localparam int unsigned SAMPLE_CYC   = SAMPLE_NS / CLK_NS;
  localparam int unsigned STROBE_HI_CYC =
    (STROBE_HI_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned FRAME_CYC    = FRAME_US * 1000 / CLK_NS;
  localparam int unsigned PERMIT_CYC   = (PERMIT_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // Controller registers (byte addresses)
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS   = 8'h08;
  localparam logic [7:0] TXDATA_OFS = 8'h0C;
  localparam logic [7:0] RXDATA_OFS = 8'h10;
  localparam logic [7:0] FLOW_OFS   = 8'h14;

  // CTRL bits
  localparam int unsigned CTRL_LP_BIT  = 0;
  localparam int unsigned CTRL_STB_BIT = 1;

  // STATUS and MASK bits
  localparam int unsigned EV_TXRDY_BIT = 0;
  localparam int unsigned EV_HOLD_BIT  = 1;
  localparam int unsigned EV_SENT_BIT  = 2;
  localparam int unsigned EV_W         = 3;

  // FLOW bits
  localparam int unsigned FL_HOLD_BIT = 0;
  localparam int unsigned FL_TXRDY_BIT = 1;
  localparam int unsigned FL_BUSY_BIT = 2;

endpackage : pfl_pkg

// ===== inc/pfl_if.sv
// ============================================================
// Packet flow link between host controller and device
interface pfl_if;
  logic       rx_flow_hold_n;        // Device: high = cannot accept
  logic       pkt_valid;             // Host: one inbound byte
  logic [7:0] pkt_data;              // Host: inbound byte
  logic       tx_ready;              // Device: outbound packet pending
  logic       tx_rd;                 // Host: takes one outbound byte
  logic [7:0] tx_data;               // Device: current outbound byte
  logic       encoder_frame_strobe;  // Host: encoder frame timing
  logic       standby_permit_n;      // Host: standby permit, low active

  modport dev (
    output rx_flow_hold_n,
    input  pkt_valid,
    input  pkt_data,
    output tx_ready,
    input  tx_rd,
    output tx_data,
    input  encoder_frame_strobe,
    input  standby_permit_n
  );

  modport host (
    input  rx_flow_hold_n,
    output pkt_valid,
    output pkt_data,
    input  tx_ready,
    output tx_rd,
    input  tx_data,
    output encoder_frame_strobe,
    output standby_permit_n
  );
endinterface : pfl_if

// ===== logic/pfl_dev.sv
// ============================================================
// Device end: flow control, transmit pending, frame timing
//
// Register access over APB and the register offsets were chosen for this implementation.
module pfl_dev #(
  parameter int unsigned SAMPLE_CYC = pfl_pkg::SAMPLE_CYC
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  pfl_if.dev              lnk,
  input  wire logic       lp_en,
  input  wire logic       skew_en,
  input  wire logic       spi_sel,
  input  wire logic       in_rd,
  output logic [7:0]      in_data,
  output logic [6:0]      in_count,
  input  wire logic       out_wr,
  input  wire logic [7:0] out_byte,
  input  wire logic       out_send,
  input  wire logic       thr_load,
  input  wire logic [6:0] thr_stop,
  input  wire logic [6:0] thr_resume,
  input  wire logic       codec_frame_sync_n,
  input  wire logic       spi_slave_enable_in,
  output logic            spi_enable_gen_out,
  output logic            spi_frame_active,
  output logic [8:0]      frame_samples,
  output logic            standby_n,
  output logic            idle_n
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [63:0][7:0] ibuf;
    logic [5:0]       wp;
    logic [5:0]       rp;
    logic [6:0]       cnt;
    logic [7:0]       in_data;
    logic             hold;
    logic [6:0]       stop;
    logic [6:0]       resume;
    logic [63:0][7:0] obuf;
    logic [6:0]       olen;
    logic [5:0]       optr;
    logic             tx_pend;
    logic [7:0]       tx_data;
    logic             strobe_d;
    logic             seen;
    logic [15:0]      smp_div;
    logic [8:0]       smp_cnt;
    logic [8:0]       frame_samples;
    logic             gen;
    logic             frame_act;
    logic             standby_n;
    logic             idle_n;
  } pfl_dev_s;

  pfl_dev_s s_ff;
  pfl_dev_s nxt_s;

  // Per-cycle decode helpers
  logic       wr;
  logic       rd;
  logic [6:0] free_sp;
  logic       rise;
  logic       active;

  // ==========================================================
  // Next state
  always_comb begin
    nxt_s = s_ff;

    // Inbound buffer write and drain
    wr = lnk.pkt_valid && (s_ff.cnt != 7'(pfl_pkg::BUF_DEPTH));
    rd = in_rd && (s_ff.cnt != 7'h00);
    if (wr) begin
      nxt_s.ibuf[s_ff.wp] = lnk.pkt_data;
      nxt_s.wp = s_ff.wp + 6'h01;
    end

    // Hand the oldest byte to the local reader
    if (rd) begin
      nxt_s.in_data = s_ff.ibuf[s_ff.rp];
      nxt_s.rp = s_ff.rp + 6'h01;
    end

    // Fill level moves by at most one either way
    nxt_s.cnt = s_ff.cnt + {6'h00, wr} - {6'h00, rd};

    // Flow pin from free space, same for every interface   // RULE8
    free_sp = 7'(pfl_pkg::BUF_DEPTH) - nxt_s.cnt;
    // Strict compares: equal levels stay in the hold band
    if (free_sp < s_ff.stop) begin
      nxt_s.hold = 1'b1;                                  // RULE2
    end else if (free_sp > s_ff.resume) begin
      nxt_s.hold = 1'b0;                                  // RULE3
    end else begin
      nxt_s.hold = s_ff.hold;                             // RULE4
    end

    // Threshold field of a control packet
    if (thr_load) begin
      nxt_s.stop   = thr_stop;                            // RULE6
      nxt_s.resume = thr_resume;                          // RULE6
    end

    // Outbound packet assembly, frozen while pending
    if (out_wr && !s_ff.tx_pend &&
        (s_ff.olen != 7'(pfl_pkg::BUF_DEPTH))) begin
      nxt_s.obuf[s_ff.olen[5:0]] = out_byte;
      nxt_s.olen = s_ff.olen + 7'h01;
    end

    // Freeze a non-empty packet and announce it
    if (out_send && !s_ff.tx_pend && (s_ff.olen != 7'h00)) begin
      nxt_s.tx_pend = 1'b1;                               // RULE12
      nxt_s.optr = 6'h00;
    end

    // Each read strobe steps on; the last one ends it
    if (lnk.tx_rd && s_ff.tx_pend) begin
      nxt_s.optr = s_ff.optr + 6'h01;
      if (({1'b0, s_ff.optr} + 7'h01) == s_ff.olen) begin
        nxt_s.tx_pend = 1'b0;                             // RULE13
        nxt_s.olen = 7'h00;
        nxt_s.optr = 6'h00;
      end
    end
    nxt_s.tx_data = nxt_s.obuf[nxt_s.optr];

    // Samples per frame from strobe rising edges
    nxt_s.strobe_d = lnk.encoder_frame_strobe;
    rise = lnk.encoder_frame_strobe && !s_ff.strobe_d;

    // Sample ticks only run while skew control is on
    if (skew_en) begin
      if (s_ff.smp_div == 16'(SAMPLE_CYC - 1)) begin
        nxt_s.smp_div = 16'h0000;
        if (s_ff.smp_cnt != 9'h1FF) begin
          nxt_s.smp_cnt = s_ff.smp_cnt + 9'h001;
        end
      end else begin
        nxt_s.smp_div = s_ff.smp_div + 16'h0001;
      end

      // A tick landing on this edge still counts toward the frame
      if (rise) begin
        if (s_ff.seen) begin
          nxt_s.frame_samples = nxt_s.smp_cnt;            // RULE11
        end
        nxt_s.seen = 1'b1;
        nxt_s.smp_cnt = 9'h000;
        nxt_s.smp_div = 16'h0000;
      end
    end else begin
      nxt_s.seen = 1'b0;
      nxt_s.smp_cnt = 9'h000;
      nxt_s.smp_div = 16'h0000;
    end

    // Activity; permit only counts in low power mode
    active = (s_ff.cnt != 7'h00) || s_ff.tx_pend || lnk.pkt_valid ||
             (skew_en && lnk.encoder_frame_strobe) ||
             (lp_en && !lnk.standby_permit_n);            // RULE15

    // Standby needs low power mode, idle needs it off
    nxt_s.standby_n = !(lp_en && !active);                // RULE18
    nxt_s.idle_n    = !(!lp_en && !active);               // RULE18

    // Codec serial enable loop-back
    nxt_s.gen = spi_sel ? codec_frame_sync_n : 1'b1;      // RULE17
    nxt_s.frame_act = spi_sel && !spi_slave_enable_in;    // RULE16
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_ff           <= '0;
      // Thresholds come up at their defaults
      s_ff.stop      <= pfl_pkg::STOP_RST;                // RULE5
      s_ff.resume    <= pfl_pkg::RESUME_RST;              // RULE5
      s_ff.gen       <= 1'b1;
      s_ff.standby_n <= 1'b1;
      s_ff.idle_n    <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // Outputs
  // Link side
  assign lnk.rx_flow_hold_n = s_ff.hold;                 // RULE1
  assign lnk.tx_ready       = s_ff.tx_pend;
  assign lnk.tx_data        = s_ff.tx_data;

  // Local reader side
  assign in_data            = s_ff.in_data;
  assign in_count           = s_ff.cnt;

  // Codec loop-back and frame measurement
  assign spi_enable_gen_out = s_ff.gen;
  assign spi_frame_active   = s_ff.frame_act;
  assign frame_samples      = s_ff.frame_samples;

  // Power state indications
  assign standby_n          = s_ff.standby_n;
  assign idle_n             = s_ff.idle_n;

endmodule : pfl_dev

// ===== logic/pfl_host.sv
// ============================================================
// Host end: APB-controlled packet sender and reader
module pfl_host #(
  parameter int unsigned FRAME_CYC     = pfl_pkg::FRAME_CYC,
  parameter int unsigned STROBE_HI_CYC = pfl_pkg::STROBE_HI_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  pfl_if.host              lnk,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0]  ctrl;
    logic [2:0]  sts;
    logic [2:0]  mask;
    logic [7:0]  txbyte;
    logic        txpend;
    logic        valid;
    logic [7:0]  pdata;
    logic [4:0]  permit_cnt;
    logic [19:0] stb_cnt;
    logic        strobe;
    logic        rd;
    logic [31:0] prdata;
    logic        perr;
    logic        hold_d;
    logic        rdy_d;
  } pfl_host_s;

  pfl_host_s s_ff;
  pfl_host_s nxt_s;

  logic       acc;
  logic       mapped;
  logic [2:0] ev;
  logic       permit_ok;

  // ==========================================================
  // Next state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.valid = 1'b0;
    nxt_s.rd = 1'b0;
    acc = psel && penable;
    mapped = (paddr <= pfl_pkg::FLOW_OFS) && (paddr[1:0] == 2'h0);

    // Read data and error prepared in setup cycle
    if (psel && !penable) begin
      nxt_s.perr = !mapped;
      nxt_s.prdata = 32'h00000000;
      case (paddr)
        pfl_pkg::CTRL_OFS:   nxt_s.prdata[1:0] = s_ff.ctrl;
        pfl_pkg::STATUS_OFS: nxt_s.prdata[2:0] = s_ff.sts;
        pfl_pkg::MASK_OFS:   nxt_s.prdata[2:0] = s_ff.mask;
        pfl_pkg::RXDATA_OFS: nxt_s.prdata[7:0] = lnk.tx_data;
        pfl_pkg::FLOW_OFS: begin
          nxt_s.prdata[pfl_pkg::FL_HOLD_BIT]  = !lnk.rx_flow_hold_n;
          nxt_s.prdata[pfl_pkg::FL_TXRDY_BIT] = lnk.tx_ready;
          nxt_s.prdata[pfl_pkg::FL_BUSY_BIT]  = s_ff.txpend;
        end
        default: nxt_s.prdata = 32'h00000000;
      endcase
    end

    // Events, set wins over clear
    nxt_s.hold_d = lnk.rx_flow_hold_n;
    nxt_s.rdy_d  = lnk.tx_ready;
    ev = 3'h0;
    ev[pfl_pkg::EV_TXRDY_BIT] = lnk.tx_ready && !s_ff.rdy_d;
    ev[pfl_pkg::EV_HOLD_BIT]  = lnk.rx_flow_hold_n && !s_ff.hold_d;

    // Permit lead time before any send in low power mode
    if (s_ff.ctrl[pfl_pkg::CTRL_LP_BIT]) begin
      if (s_ff.permit_cnt != 5'(pfl_pkg::PERMIT_CYC)) begin
        nxt_s.permit_cnt = s_ff.permit_cnt + 5'h01;       // RULE14
      end
    end else begin
      nxt_s.permit_cnt = 5'h00;
    end
    permit_ok = !s_ff.ctrl[pfl_pkg::CTRL_LP_BIT] ||
                (s_ff.permit_cnt == 5'(pfl_pkg::PERMIT_CYC));

    // Send one byte when device accepts
    if (s_ff.txpend && !lnk.rx_flow_hold_n && permit_ok) begin
      nxt_s.valid  = 1'b1;                                // RULE14
      nxt_s.pdata  = s_ff.txbyte;
      nxt_s.txpend = 1'b0;
      ev[pfl_pkg::EV_SENT_BIT] = 1'b1;
    end

    // Register writes and read side effects
    if (acc && pwrite) begin
      case (paddr)
        pfl_pkg::CTRL_OFS:   nxt_s.ctrl = pwdata[1:0];
        pfl_pkg::STATUS_OFS: nxt_s.sts = s_ff.sts & ~pwdata[2:0];
        pfl_pkg::MASK_OFS:   nxt_s.mask = pwdata[2:0];
        pfl_pkg::TXDATA_OFS: begin
          if (!s_ff.txpend) begin
            nxt_s.txbyte = pwdata[7:0];
            nxt_s.txpend = 1'b1;
          end
        end
        default: nxt_s.ctrl = nxt_s.ctrl;
      endcase
    end
    if (acc && !pwrite && (paddr == pfl_pkg::RXDATA_OFS)) begin
      nxt_s.rd = lnk.tx_ready;                            // RULE13
    end
    nxt_s.sts = nxt_s.sts | ev;

    // Encoder frame strobe generator
    if (s_ff.ctrl[pfl_pkg::CTRL_STB_BIT]) begin
      if (s_ff.stb_cnt == 20'(FRAME_CYC - 1)) begin
        nxt_s.stb_cnt = 20'h00000;                        // RULE10
      end else begin
        nxt_s.stb_cnt = s_ff.stb_cnt + 20'h00001;
      end
      nxt_s.strobe = nxt_s.stb_cnt < 20'(STROBE_HI_CYC);  // RULE9
    end else begin
      // Parked on the last count so the first pulse is full width
      nxt_s.stb_cnt = 20'(FRAME_CYC - 1);
      nxt_s.strobe = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_ff        <= '0;
      s_ff.hold_d <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // Outputs
  assign lnk.pkt_valid            = s_ff.valid;
  assign lnk.pkt_data             = s_ff.pdata;
  assign lnk.tx_rd                = s_ff.rd;
  assign lnk.encoder_frame_strobe = s_ff.strobe;
  assign lnk.standby_permit_n     = !s_ff.ctrl[pfl_pkg::CTRL_LP_BIT];
  assign prdata                   = s_ff.prdata;
  assign pslverr                  = psel && penable && s_ff.perr;
  assign pready                   = 1'b1;
  assign irq                      = |(s_ff.sts & s_ff.mask);

endmodule : pfl_host

// ===== verif/pfl_assertions.sv
// ==========================================================
// Link checks between host end and device end
module pfl_assertions #(
  parameter int unsigned FRAME_CYC     = 200,
  parameter int unsigned STROBE_HI_CYC = 20
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       rx_flow_hold_n,
  input wire logic       pkt_valid,
  input wire logic       tx_ready,
  input wire logic       tx_rd,
  input wire logic [7:0] tx_data,
  input wire logic       encoder_frame_strobe,
  input wire logic       standby_permit_n
);
  timeunit 1ns;
  timeprecision 100ps;

  logic        stb_ff;
  logic        seen_ff;
  logic        stb_rise;
  logic [31:0] hi_ff;
  logic [31:0] per_ff;
  logic [31:0] low_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  assign stb_rise = encoder_frame_strobe & ~stb_ff;

  // Strobe width, strobe period and permit-low counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stb_ff  <= 1'b0;
      seen_ff <= 1'b0;
      hi_ff   <= 32'h0;
      per_ff  <= 32'h0;
      low_ff  <= 32'h0;
    end else begin
      stb_ff  <= encoder_frame_strobe;
      seen_ff <= seen_ff | stb_rise;
      hi_ff   <= encoder_frame_strobe ? hi_ff + 32'h1 : 32'h0;
      per_ff  <= stb_rise ? 32'h1 : per_ff + 32'h1;
      low_ff  <= standby_permit_n ? 32'h0 : low_ff + 32'h1;
    end
  end

  property p_tx_hold;
    tx_ready && !tx_rd |=> tx_ready;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("pending flag fell with no read");
  property p_rd_ready;
    tx_rd |-> tx_ready;
  endproperty
  a_rd_ready: assert property (p_rd_ready)
    else $error("read strobe with nothing pending");
  property p_data_stable;
    tx_ready && $past(tx_ready) && !tx_rd && !$past(tx_rd) |=>
      $stable(tx_data);
  endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("outbound byte changed without a read");
  property p_hold_rise;
    $rose(rx_flow_hold_n) |-> $past(pkt_valid);
  endproperty
  a_hold_rise: assert property (p_hold_rise)
    else $error("flow hold rose without an inbound byte");
  property p_hold_send;
    rx_flow_hold_n [*3] |-> !pkt_valid;
  endproperty
  a_hold_send: assert property (p_hold_send)
    else $error("byte sent while device holds flow");
  property p_stb_hi;
    !encoder_frame_strobe && stb_ff |-> hi_ff == STROBE_HI_CYC;
  endproperty
  a_stb_hi: assert property (p_stb_hi)
    else $error("frame strobe width wrong");
  property p_stb_per;
    stb_rise && seen_ff |-> per_ff == FRAME_CYC;
  endproperty
  a_stb_per: assert property (p_stb_per)
    else $error("frame strobe period wrong");
  property p_permit;
    pkt_valid && !standby_permit_n |-> low_ff >= pfl_pkg::PERMIT_CYC;
  endproperty
  a_permit: assert property (p_permit)
    else $error("byte sent too soon after standby permit");

  c_hold: cover property ($rose(rx_flow_hold_n));
  c_tx_done: cover property ($fell(tx_ready));
  c_period: cover property (stb_rise && seen_ff);
  c_permit: cover property (pkt_valid && !standby_permit_n);
endmodule : pfl_assertions

// ===== verif/packet_flow_and_frame_timing_tb_top.sv
// ==========================================================
// Bench for host end and device end joined back to back
module packet_flow_and_frame_timing_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned FRAME = 200;
  localparam int unsigned SMP   = 10;
  localparam int unsigned SHI   = 20;

  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, in_data, out_byte;
  logic [31:0] pwdata, prdata, rdata;
  logic        lp_en, skew_en, spi_sel, in_rd, out_wr, out_send, rerr;
  logic        thr_load, codec_frame_sync_n, spi_slave_enable_in;
  logic        spi_enable_gen_out, spi_frame_active, standby_n, idle_n;
  logic [6:0]  in_count, thr_stop, thr_resume;
  logic [8:0]  frame_samples;
  logic        exph;
  int          cnt, stp, rsm, err_total, n_tests;

  pfl_if lnk ();

  pfl_dev #(.SAMPLE_CYC(SMP)) i_pfl_dev (
    .clk, .resetn, .lnk, .lp_en, .skew_en, .spi_sel, .in_rd, .in_data,
    .in_count, .out_wr, .out_byte, .out_send, .thr_load, .thr_stop,
    .thr_resume, .codec_frame_sync_n, .spi_slave_enable_in,
    .spi_enable_gen_out, .spi_frame_active, .frame_samples, .standby_n,
    .idle_n
  );

  pfl_host #(.FRAME_CYC(FRAME), .STROBE_HI_CYC(SHI)) i_pfl_host (
    .clk, .resetn, .lnk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq
  );

  pfl_assertions #(.FRAME_CYC(FRAME), .STROBE_HI_CYC(SHI)) i_chk (
    .clk, .resetn,
    .rx_flow_hold_n       (lnk.rx_flow_hold_n),
    .pkt_valid            (lnk.pkt_valid),
    .tx_ready             (lnk.tx_ready),
    .tx_rd                (lnk.tx_rd),
    .tx_data              (lnk.tx_data),
    .encoder_frame_strobe (lnk.encoder_frame_strobe),
    .standby_permit_n     (lnk.standby_permit_n)
  );

  // Enable loop-back wiring
  assign spi_slave_enable_in = spi_enable_gen_out;

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    psel   <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic upd();
    if (64 - cnt < stp) exph = 1'b1;
    else if (64 - cnt > rsm) exph = 1'b0;
    @(negedge clk);
    chk(lnk.rx_flow_hold_n, exph);
    chk(in_count, cnt);
  endtask : upd

  task automatic send(input logic [7:0] b);
    apb(1'b1, pfl_pkg::TXDATA_OFS, {24'h0, b});
    do apb(1'b0, pfl_pkg::FLOW_OFS, 32'h0); while (rdata[2] !== 1'b0);
    cnt++;
    upd();
  endtask : send

  task automatic pop(input logic [7:0] e);
    @(posedge clk);
    in_rd <= 1'b1;
    @(posedge clk);
    in_rd <= 1'b0;
    @(negedge clk);
    chk(in_data, e);
    cnt--;
    upd();
  endtask : pop

  // ==========================================================
  // Scenarios
  task automatic t_flow();
    for (int i = 0; i < 45; i++) send(i[7:0]);
    apb(1'b0, pfl_pkg::STATUS_OFS, 32'h0);
    chk(rdata[1], 1'b1);
    apb(1'b1, pfl_pkg::MASK_OFS, 32'h2);
    repeat (2) @(negedge clk);
    chk(irq, 1'b1);
    apb(1'b1, pfl_pkg::STATUS_OFS, 32'h2);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    apb(1'b1, pfl_pkg::MASK_OFS, 32'h0);
    for (int i = 0; i < 22; i++) pop(i[7:0]);
    @(posedge clk);
    thr_stop   <= 7'h29;
    thr_resume <= 7'h32;
    thr_load   <= 1'b1;
    @(posedge clk);
    thr_load <= 1'b0;
    stp = 41;
    rsm = 50;
    send(8'hC3);
    for (int i = 22; i < 45; i++) pop(i[7:0]);
    pop(8'hC3);
  endtask : t_flow

  task automatic t_tx();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      out_wr   <= (i < 3);
      out_send <= (i == 3);
      out_byte <= 8'hA0 + i[7:0];
    end
    @(posedge clk);
    out_send <= 1'b0;
    repeat (2) @(negedge clk);
    chk(lnk.tx_ready, 1'b1);
    apb(1'b0, pfl_pkg::STATUS_OFS, 32'h0);
    chk(rdata[0], 1'b1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, pfl_pkg::RXDATA_OFS, 32'h0);
      chk(rdata, 32'hA0 + i);
      repeat (3) @(negedge clk);
      chk(lnk.tx_ready, i < 2);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(rerr, 1'b1);
    chk(rdata, 32'h0);
  endtask : t_tx

  task automatic t_lp();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      lp_en <= i[1];
      apb(1'b1, pfl_pkg::CTRL_OFS, {31'h0, i[0] ^ i[1]});
      repeat (4) @(negedge clk);
      chk(idle_n, i[1]);
      chk(standby_n, i != 3);
      if (i == 2) send(8'h5A);
      if (i == 2) pop(8'h5A);
    end
    apb(1'b1, pfl_pkg::CTRL_OFS, 32'h1);
    send(8'h3C);
    pop(8'h3C);
  endtask : t_lp

  task automatic t_spi();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      spi_sel            <= !i[1];
      codec_frame_sync_n <= i[0];
      repeat (3) @(negedge clk);
      chk(spi_enable_gen_out, i[0] | i[1]);
      chk(spi_frame_active, !(i[0] | i[1]));
    end
  endtask : t_spi

  task automatic t_frame();
    @(posedge clk);
    skew_en <= 1'b1;
    apb(1'b1, pfl_pkg::CTRL_OFS, 32'h2);
    repeat (700) @(negedge clk);
    chk(frame_samples, FRAME / SMP);
  endtask : t_frame

  task automatic give_verdict();
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Clock, main sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {lp_en, skew_en, spi_sel, in_rd, out_wr, out_byte, out_send} = '0;
    {thr_load, thr_stop, thr_resume} = '0;
    codec_frame_sync_n = 1'b1;
    {cnt, err_total, n_tests} = '0;
    stp  = 20;
    rsm  = 40;
    exph = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk(lnk.rx_flow_hold_n, 1'b0);
    chk(lnk.tx_ready, 1'b0);
    chk(lnk.standby_permit_n, 1'b1);
    t_flow();
    t_tx();
    t_lp();
    t_spi();
    t_frame();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end
endmodule : packet_flow_and_frame_timing_tb_top
